//--- hw/timer2_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer/event counter
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes:   Register byte offsets are word aligned
package timer2_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] COUNT_OFS   = 8'h04;
   localparam logic [7:0] CAPTURE_OFS = 8'h08;
   localparam logic [7:0] MODE_OFS    = 8'h0C;

   // ----------------------------------------------------------------
   // Control and mode bit positions
   // ----------------------------------------------------------------
   localparam int CRL_BIT  = 0;
   localparam int CT_BIT   = 1;
   localparam int RUN_BIT  = 2;
   localparam int EXEN_BIT = 3;
   localparam int TRANSMIT_CLOCK_SELECT_BIT = 4;
   localparam int RCLK_BIT = 5;
   localparam int EXF_BIT  = 6;
   localparam int TF_BIT   = 7;
   localparam int DOWN_COUNT_ENABLE_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [15:0] CAPTURE_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [3:0]  PHASES      = 4'hC;
   localparam logic [3:0]  SAMPLE_PH   = 4'h9;
   localparam logic [3:0]  UPDATE_PH   = 4'h4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum {MODE_OFF, MODE_RELOAD, MODE_CAPTURE, MODE_BAUD} t2_mode_t;

   typedef struct packed {
      logic tf;
      logic exf;
      logic rclk;
      logic transmit_clock_select;
      logic exen;
      logic run;
      logic ct;
      logic crl;
   } t2_ctrl_t;

endpackage : timer2_pkg

//--- hw/sync_fall.sv
// Purpose: Two-flop synchroniser with falling-edge pulse on a sampled strobe
// Assumes: Input is asynchronous to clk
// Notes:   Edge is judged between two samples taken at sample_en
module sync_fall
   import timer2_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Pin and strobe
   input  wire logic pin_in,
   input  wire logic sample_en,
   // Results
   output logic      level,
   output logic      fall
);
   logic meta_ff, sync_ff, smp_ff, prev_ff;
   logic nxt_smp, nxt_prev;

   always_comb begin
      nxt_smp  = smp_ff;
      nxt_prev = prev_ff;
      if (sample_en) begin
         nxt_prev = smp_ff;
         nxt_smp  = sync_ff;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         smp_ff  <= 1'b1;
         prev_ff <= 1'b1;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         smp_ff  <= nxt_smp;
         prev_ff <= nxt_prev;
      end
   end

   // Only sampled values are compared, so glitches between samples are ignored
   assign level = smp_ff;
   assign fall  = prev_ff & ~smp_ff;
endmodule : sync_fall

//--- hw/phase_gen.sv
// Purpose: Machine-cycle phase counter, twelve clocks per machine cycle
// Assumes: clk is the oscillator
// Notes:   Phase index 0 is state1 phase1
module phase_gen
   import timer2_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Phase outputs
   output logic [3:0]      phase,
   output logic            state_tick
);
   logic [3:0] ph_ff;
   logic [3:0] nxt_ph;

   always_comb begin
      nxt_ph = (ph_ff == PHASES - 4'h1) ? 4'h0 : ph_ff + 4'h1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_ff <= 4'h0;
      end else begin
         ph_ff <= nxt_ph;
      end
   end

   assign phase      = ph_ff;
   assign state_tick = ph_ff[0];
endmodule : phase_gen

//--- hw/timer2_capture_counter.sv
// Purpose: 16-bit timer/event counter with capture, reload and baud modes
// Assumes: clk is the oscillator; AXI4-Lite slave; pins asynchronous
// Notes on behaviour
// - 16-bit counter, timer or event counter
// - counter_timer_select chooses timer or counter
// - Count held as high and low bytes
// - Timer advances once per machine cycle, every two clocks in baud mode
// - Count input sampled at state5_phase2
// - Count on high sample then low sample
// - New count visible at state3_phase1 after
// - Max external rate oscillator over 24
// - Capture, auto-reload, baud generator, or off
// - Mode decoded from run, clock and reload selects
// - Capture mode counts, overflow sets overflow flag
// - Overflow flag drives interrupt request
// - Trigger enable keeps counting behaviour unchanged
// - Trigger falling edge copies count to capture
// - Trigger falling edge sets trigger flag
// - Trigger flag drives interrupt request
// - Auto-reload overflow sets flag and reloads
// - Baud rollover sets no flag, no interrupt
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
module timer2_capture_counter
   import timer2_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pins
   input  wire logic        t2_count_input,
   input  wire logic        t2_external_trigger,
   // Requests
   output logic             t2_overflow_irq,
   output logic             ext_trigger_irq
);
   // ----------------------------------------------------------------
   // Phase and pin sampling
   // ----------------------------------------------------------------
   logic [3:0] phase;
   logic       state_tick;
   logic       cnt_fall, trg_level, trg_fall;
   logic       smp_en, upd_en, fall_en;

   phase_gen u_phase (
      .clk        (clk),
      .reset_n    (reset_n),
      .phase      (phase),
      .state_tick (state_tick)
   );

   assign smp_en = (phase == SAMPLE_PH);
   assign upd_en = (phase == UPDATE_PH);
   // Edges act one clock after the sample, while the fall flag is fresh;
   // acting at the next sample would add a whole machine cycle of delay
   assign fall_en = (phase == SAMPLE_PH + 4'h1);

   sync_fall u_cnt (
      .clk       (clk),
      .reset_n   (reset_n),
      .pin_in    (t2_count_input),
      .sample_en (smp_en),
      .level     (),
      .fall      (cnt_fall)
   );

   sync_fall u_trg (
      .clk       (clk),
      .reset_n   (reset_n),
      .pin_in    (t2_external_trigger),
      .sample_en (smp_en),
      .level     (trg_level),
      .fall      (trg_fall)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   t2_ctrl_t    ctrl_ff, nxt_ctrl;
   logic        down_count_enable_ff, nxt_down_count_enable;
   logic [7:0]  cnt_hi_ff, nxt_cnt_hi, cnt_lo_ff, nxt_cnt_lo;
   logic [15:0] cap_ff, nxt_cap;
   logic        pend_ff, nxt_pend;
   logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
   logic [7:0]  awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [3:0]  ws_ff, nxt_ws;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   t2_mode_t    mode;
   logic        ev_fall_used, trg_ev_used;
   logic [15:0] count, incd, decd;
   logic        inc, ovf, wr_go, tf_set, exf_set, exf_tog;

   assign count = {cnt_hi_ff, cnt_lo_ff};
   assign incd  = count + 16'h0001;
   assign decd  = count - 16'h0001;

   // Mode decode
   always_comb begin
      if (!ctrl_ff.run) begin
         mode = MODE_OFF;
      end else if (ctrl_ff.rclk | ctrl_ff.transmit_clock_select) begin
         mode = MODE_BAUD;
      end else if (ctrl_ff.crl) begin
         mode = MODE_CAPTURE;
      end else begin
         mode = MODE_RELOAD;
      end
   end

   // Count source: a counter edge waits for the update phase of the next cycle
   always_comb begin
      ev_fall_used = pend_ff & upd_en;
      if (mode == MODE_OFF) begin
         inc = 1'b0;
      end else if (ctrl_ff.ct) begin
         inc = ev_fall_used;
      end else if (mode == MODE_BAUD) begin
         inc = state_tick;
      end else begin
         inc = upd_en;
      end
   end

   always_comb begin
      nxt_pend = pend_ff;
      if (cnt_fall && fall_en) begin
         nxt_pend = 1'b1;
      end else if (upd_en) begin
         nxt_pend = 1'b0;
      end
   end

   assign trg_ev_used = trg_fall & fall_en & ctrl_ff.exen;
   assign ovf = inc && (count == COUNT_MAX) && !(down_count_enable_ff && !trg_level && mode == MODE_RELOAD);
   assign wr_go = aw_ff & w_ff & ~b_ff;

   // Counter, capture and flags
   always_comb begin
      nxt_cnt_hi = cnt_hi_ff;
      nxt_cnt_lo = cnt_lo_ff;
      nxt_cap    = cap_ff;
      tf_set     = 1'b0;
      exf_set    = 1'b0;
      exf_tog    = 1'b0;
      if (inc) begin
         if (mode == MODE_RELOAD && down_count_enable_ff && !trg_level) begin
            if (count == cap_ff) begin
               {nxt_cnt_hi, nxt_cnt_lo} = COUNT_MAX;
               tf_set  = 1'b1;
               exf_tog = 1'b1;
            end else begin
               {nxt_cnt_hi, nxt_cnt_lo} = decd;
            end
         end else if (ovf && mode != MODE_CAPTURE) begin
            {nxt_cnt_hi, nxt_cnt_lo} = cap_ff;
            tf_set  = (mode == MODE_RELOAD);
            exf_tog = (mode == MODE_RELOAD) && down_count_enable_ff;
         end else begin
            {nxt_cnt_hi, nxt_cnt_lo} = incd;
            tf_set = ovf;
         end
      end
      if (trg_ev_used) begin
         exf_set = ~(mode == MODE_RELOAD && down_count_enable_ff);
         if (mode == MODE_CAPTURE) begin
            nxt_cap = count;
         end else if (mode == MODE_RELOAD && !down_count_enable_ff) begin
            {nxt_cnt_hi, nxt_cnt_lo} = cap_ff;
         end
      end
      if (wr_go && awa_ff == COUNT_OFS) begin
         if (ws_ff[0]) nxt_cnt_lo = wd_ff[7:0];
         if (ws_ff[1]) nxt_cnt_hi = wd_ff[15:8];
      end
      if (wr_go && awa_ff == CAPTURE_OFS) begin
         if (ws_ff[0]) nxt_cap[7:0]  = wd_ff[7:0];
         if (ws_ff[1]) nxt_cap[15:8] = wd_ff[15:8];
      end
   end

   // Control register: hardware set wins over software clear
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_down_count_enable = down_count_enable_ff;
      if (wr_go && awa_ff == CTRL_OFS && ws_ff[0]) begin
         nxt_ctrl = t2_ctrl_t'(wd_ff[7:0]);
      end
      if (wr_go && awa_ff == MODE_OFS && ws_ff[0]) begin
         nxt_down_count_enable = wd_ff[DOWN_COUNT_ENABLE_BIT];
      end
      if (tf_set) nxt_ctrl.tf = 1'b1;
      if (exf_tog) nxt_ctrl.exf = ~ctrl_ff.exf;
      if (exf_set) nxt_ctrl.exf = 1'b1;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_comb begin
      nxt_aw = aw_ff;  nxt_w = w_ff;  nxt_b = b_ff;  nxt_r = r_ff;
      nxt_awa = awa_ff;  nxt_wd = wd_ff;  nxt_ws = ws_ff;
      nxt_bresp = bresp_ff;  nxt_rresp = rresp_ff;  nxt_rd = rd_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw = 1'b1;  nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w = 1'b1;  nxt_wd = s_axi_wdata;  nxt_ws = s_axi_wstrb;
      end
      if (wr_go) begin
         nxt_aw = 1'b0;  nxt_w = 1'b0;  nxt_b = 1'b1;
         nxt_bresp = (awa_ff == CTRL_OFS || awa_ff == COUNT_OFS || awa_ff == CAPTURE_OFS
                      || awa_ff == MODE_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_ff && s_axi_bready) nxt_b = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_r = 1'b1;
         nxt_rresp = RESP_OKAY;
         case (s_axi_araddr)
            CTRL_OFS:    nxt_rd = {24'h000000, ctrl_ff};
            COUNT_OFS:   nxt_rd = {16'h0000, count};
            CAPTURE_OFS: nxt_rd = {16'h0000, cap_ff};
            MODE_OFS:    nxt_rd = {31'h00000000, down_count_enable_ff};
            default: begin
               nxt_rd = 32'h00000000;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (r_ff && s_axi_rready) nxt_r = 1'b0;
   end

   assign s_axi_awready = ~aw_ff & ~b_ff;
   assign s_axi_wready  = ~w_ff & ~b_ff;
   assign s_axi_arready = ~r_ff;
   assign s_axi_bvalid  = b_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_rvalid  = r_ff;
   assign s_axi_rdata   = rd_ff;
   assign s_axi_rresp   = rresp_ff;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff   <= t2_ctrl_t'(CTRL_RST);
         down_count_enable_ff   <= 1'b0;
         {cnt_hi_ff, cnt_lo_ff} <= COUNT_RST;
         cap_ff    <= CAPTURE_RST;
         pend_ff   <= 1'b0;
         aw_ff <= 1'b0;  w_ff <= 1'b0;  b_ff <= 1'b0;  r_ff <= 1'b0;
         awa_ff <= 8'h00;  wd_ff <= 32'h00000000;  ws_ff <= 4'h0;
         bresp_ff <= RESP_OKAY;  rresp_ff <= RESP_OKAY;  rd_ff <= 32'h00000000;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         down_count_enable_ff   <= nxt_down_count_enable;
         cnt_hi_ff <= nxt_cnt_hi;
         cnt_lo_ff <= nxt_cnt_lo;
         cap_ff    <= nxt_cap;
         pend_ff   <= nxt_pend;
         aw_ff <= nxt_aw;  w_ff <= nxt_w;  b_ff <= nxt_b;  r_ff <= nxt_r;
         awa_ff <= nxt_awa;  wd_ff <= nxt_wd;  ws_ff <= nxt_ws;
         bresp_ff <= nxt_bresp;  rresp_ff <= nxt_rresp;  rd_ff <= nxt_rd;
      end
   end

   // Flags reach the interrupt controller as levels
   assign t2_overflow_irq = ctrl_ff.tf;
   assign ext_trigger_irq = ctrl_ff.exf & ~(mode == MODE_RELOAD && down_count_enable_ff);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   timer_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_CAPTURE && !ctrl_ff.ct && upd_en && count != COUNT_MAX && !wr_go)
      |=> (count == $past(count) + 16'h0001))
      else $error("timer did not step in machine cycle");
   count_only_update_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl_ff.ct && mode == MODE_CAPTURE && !upd_en && !wr_go) |=> $stable(count))
      else $error("counter moved outside update phase");
   edge_counted_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl_ff.ct && mode == MODE_CAPTURE && fall_en && cnt_fall && count != COUNT_MAX)
      ##1 (!wr_go && mode == MODE_CAPTURE && ctrl_ff.ct) [*6] |=> (count == $past(count, 7) + 16'h0001))
      else $error("falling edge not counted");
   off_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_OFF && !wr_go) |=> $stable(count))
      else $error("counter moved while off");
   capture_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_CAPTURE && trg_ev_used && !wr_go) |=> (cap_ff == $past(count)))
      else $error("capture did not take count");
   trig_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_CAPTURE && trg_ev_used) |=> ctrl_ff.exf)
      else $error("trigger flag not set");
   ovf_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_CAPTURE && inc && count == COUNT_MAX) |=> (ctrl_ff.tf && count == 16'h0000))
      else $error("overflow flag or wrap wrong");
   reload_ovf_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_RELOAD && !down_count_enable_ff && inc && count == COUNT_MAX && !trg_ev_used && !wr_go)
      |=> (ctrl_ff.tf && count == $past(cap_ff)))
      else $error("auto-reload overflow wrong");
   baud_no_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == MODE_BAUD && !ctrl_ff.tf && !wr_go) |=> !ctrl_ff.tf)
      else $error("baud rollover set overflow flag");
   flag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl_ff.tf && !wr_go) |=> ctrl_ff.tf)
      else $error("overflow flag cleared by hardware");
endmodule : timer2_capture_counter

//--- verification/pin_source.sv
// Purpose: Far-side model driving the count and trigger pins
// Assumes: Levels change by non-blocking assignment just after a clk edge
// Notes:   Idle level of both pins is high
module pin_source (
   // Clock
   input  wire logic clk,
   // Pins
   output logic      t2_count_input,
   output logic      t2_external_trigger
);
   timeunit 1ns;
   timeprecision 1ns;

   // Shorter levels may be missed by the once-per-cycle sampling
   localparam int MC = 12;

   initial begin
      t2_count_input      = 1'b1;
      t2_external_trigger = 1'b1;
   end

   task automatic count_pulses(input int n, input int hold);
      repeat (n) begin
         t2_count_input <= 1'b0;
         repeat ((hold < MC) ? MC : hold) @(posedge clk);
         t2_count_input <= 1'b1;
         repeat ((hold < MC) ? MC : hold) @(posedge clk);
      end
   endtask : count_pulses

   task automatic trigger_fall(input int hold);
      t2_external_trigger <= 1'b0;
      repeat ((hold < MC) ? MC : hold) @(posedge clk);
      t2_external_trigger <= 1'b1;
      repeat ((hold < MC) ? MC : hold) @(posedge clk);
   endtask : trigger_fall
endmodule : pin_source

//--- verification/timer2_capture_counter_tb.sv
// Purpose: Self-checking bench for the timer/event counter
// Assumes: AXI4-Lite master tasks, pin model drives the pins
// Notes:   Every bus wait is bounded to 50 edges
module timer2_capture_counter_tb
   import timer2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, reset_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd, c0;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, rsp;
   logic        cnt_pin, trg_pin, ovf_irq, trg_irq;
   int          n_mismatch, checks, s;
   int          cyc = 0;

   timer2_capture_counter i_dut (
      .clk(clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .t2_count_input(cnt_pin), .t2_external_trigger(trg_pin),
      .t2_overflow_irq(ovf_irq), .ext_trigger_irq(trg_irq)
   );

   pin_source i_src (.clk(clk), .t2_count_input(cnt_pin), .t2_external_trigger(trg_pin));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // Checks and bus tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic bus_stall();
      n_mismatch++;
      $display("Error bus answer expected within 50 edges seen none");
      complete_run();
   endtask : bus_stall

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n > 50) bus_stall();
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (n > 50) bus_stall();
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : axi_read

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_read(a, rd, rsp);
      chk_word(what, exp, rd);
   endtask : rd_chk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      n_mismatch = 0;
      checks = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk(CTRL_OFS, {24'h0, CTRL_RST}, "ctrl reset");
      rd_chk(COUNT_OFS, {16'h0, COUNT_RST}, "count reset");
      rd_chk(CAPTURE_OFS, {16'h0, CAPTURE_RST}, "capture reset");
      rd_chk(MODE_OFS, 32'h0, "mode reset");
      axi_read(8'h10, rd, rsp);
      chk_word("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      // Stopped counter must hold
      axi_write(COUNT_OFS, 32'h55);
      repeat (50) @(posedge clk);
      rd_chk(COUNT_OFS, 32'h55, "count while off");
      // Timer: ten machine cycles in 120 clk
      axi_write(CTRL_OFS, 32'h05);
      s = cyc;
      axi_read(COUNT_OFS, c0, rsp);
      repeat (s + 120 - cyc) @(posedge clk);
      rd_chk(COUNT_OFS, c0 + 32'h0000000A, "timer rate");
      // Counter: slow edges, then edges at the highest rate
      axi_write(CTRL_OFS, 32'h0);
      axi_write(COUNT_OFS, 32'h0);
      axi_write(CTRL_OFS, 32'h07);
      i_src.count_pulses(5, 18);
      i_src.count_pulses(4, 12);
      repeat (36) @(posedge clk);
      rd_chk(COUNT_OFS, 32'h9, "edge count");
      // Capture mode overflow, flag sticks until cleared
      axi_write(CTRL_OFS, 32'h0);
      axi_write(COUNT_OFS, 32'hFFFF);
      axi_write(CTRL_OFS, 32'h05);
      repeat (30) @(posedge clk);
      rd_chk(CTRL_OFS, 32'h85, "overflow flag");
      chk_bit("overflow irq", 1'b1, ovf_irq);
      repeat (60) @(posedge clk);
      rd_chk(CTRL_OFS, 32'h85, "flag held");
      axi_write(CTRL_OFS, 32'h0);
      rd_chk(CTRL_OFS, 32'h0, "flag cleared");
      chk_bit("overflow irq cleared", 1'b0, ovf_irq);
      // Trigger ignored while its enable is clear
      axi_write(COUNT_OFS, 32'h1234);
      axi_write(CTRL_OFS, 32'h07);
      i_src.trigger_fall(18);
      rd_chk(CAPTURE_OFS, 32'h0, "no capture");
      rd_chk(CTRL_OFS, 32'h07, "no trigger flag");
      // Trigger with enable set
      axi_write(CTRL_OFS, 32'h0F);
      i_src.trigger_fall(18);
      rd_chk(CAPTURE_OFS, 32'h1234, "captured count");
      rd_chk(CTRL_OFS, 32'h4F, "trigger flag");
      chk_bit("trigger irq", 1'b1, trg_irq);
      // Trigger enable set: timer still overflows and flags
      axi_write(CTRL_OFS, 32'h0);
      axi_write(COUNT_OFS, 32'hFFFF);
      axi_write(CTRL_OFS, 32'h0D);
      repeat (30) @(posedge clk);
      rd_chk(CTRL_OFS, 32'h8D, "overflow with trigger enable");
      // Auto-reload overflow
      axi_write(CTRL_OFS, 32'h0);
      axi_write(CAPTURE_OFS, 32'hAB00);
      axi_write(COUNT_OFS, 32'hFFFF);
      axi_write(CTRL_OFS, 32'h04);
      repeat (30) @(posedge clk);
      rd_chk(CTRL_OFS, 32'h84, "reload flag");
      axi_write(CTRL_OFS, 32'h0);
      axi_read(COUNT_OFS, rd, rsp);
      chk_word("reloaded count", 32'hAB00, rd & 32'hFF00);
      // Baud generator via either clock select, reload select ignored
      for (int i = 0; i < 2; i++) begin
         axi_write(CTRL_OFS, 32'h0);
         axi_write(COUNT_OFS, 32'hFFF0);
         axi_write(CTRL_OFS, (i == 0) ? 32'h15 : 32'h25);
         repeat (60) @(posedge clk);
         rd_chk(CTRL_OFS, (i == 0) ? 32'h15 : 32'h25, "baud no flag");
         chk_bit("baud irq", 1'b0, ovf_irq);
      end
      complete_run();
   end
endmodule : timer2_capture_counter_tb
